// *** rtl/pedsc_event_flags.sv ***
// sticky event flags with read, write and auto clear
`timescale 1ns/1ps
module pedsc_event_flags (
   input wire logic clk,
   input wire logic srst,
   input wire logic [pedsc_pkg::NUM_FLAGS-1:0] eventPulse,
   input wire logic [pedsc_pkg::NUM_FLAGS-1:0] eventLevel,
   input wire logic readClear,
   input wire logic [pedsc_pkg::NUM_FLAGS-1:0] writeClear,
   input wire logic autoClearEn,
   input wire logic resetupEn,
   output logic [pedsc_pkg::NUM_FLAGS-1:0] flags
);
   // ----------------------------------------------------------------
   // one flag per event
   // ----------------------------------------------------------------
   wire logic [pedsc_pkg::NUM_FLAGS-1:0] next_flags;
   genvar i;
   generate
      for (i = 0; i < pedsc_pkg::NUM_FLAGS; i = i + 1) begin : g_flag
         wire logic autoClr;
         wire logic wrClr;
         wire logic clr;
         assign autoClr = autoClearEn & ~eventLevel[i];
         assign wrClr = writeClear[i] & ~(resetupEn & eventLevel[i]);
         assign clr = readClear | autoClr | wrClr;
         // set wins over any clear in the same cycle
         assign next_flags[i] = eventPulse[i] | (flags[i] & ~clr);
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (srst) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule // pedsc_event_flags

// *** rtl/pedsc_pkg.sv ***
// constants and types for the phy event interrupt and deep sleep control block
package pedsc_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_IRQ_ENABLE = 5'h16;
   localparam logic [4:0] REG_IRQ_STATUS = 5'h17;
   localparam logic [4:0] REG_FIFO_SLEEP = 5'h18;
   localparam int NUM_FLAGS = 11;
   localparam int NUM_COND = 9;
   // enable register fields
   localparam int EN_GLOBAL = 15;
   localparam int EN_READ_CLEAR = 14;
   localparam int EN_POLARITY = 13;
   localparam int EN_AUTO_CLEAR = 12;
   localparam int EN_RESETUP = 11;
   localparam logic [15:0] EN_RESET = 16'h0000;
   // fifo and sleep register fields
   localparam int FS_FIFO_LSB = 12;
   localparam int FS_RSVD_LSB = 9;
   localparam int FS_SLEEP_EN = 8;
   localparam int FS_PLL = 7;
   localparam int FS_FAST_RX = 6;
   localparam int FS_TX_DAC = 5;
   localparam int FS_CLK_REC = 4;
   localparam logic [3:0] FIFO_HALF_RESET = 4'h2;
   localparam logic [5:0] FIFO_BIAS = 6'h03;
   localparam int FIFO_SCALE_SHIFT = 1;
   // ----------------------------------------------------------------
   // management frame
   // ----------------------------------------------------------------
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [4:0] OP_BITS = 5'h02;
   localparam logic [4:0] ADDR_BITS = 5'h0a;
   localparam logic [4:0] DATA_BITS = 5'h10;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   typedef enum logic [6:0] {
      FR_PREAMBLE = 7'h01,
      FR_START = 7'h02,
      FR_OPCODE = 7'h04,
      FR_ADDR = 7'h08,
      FR_TURN = 7'h10,
      FR_RDATA = 7'h20,
      FR_WDATA = 7'h40
   } pedsc_frame_e;
   typedef enum logic [1:0] {
      SL_AWAKE = 2'h1,
      SL_ASLEEP = 2'h2
   } pedsc_sleep_e;
endpackage

// *** rtl/pedsc_top.sv ***
// management slave, event interrupt and deep sleep control
`timescale 1ns/1ps
module pedsc_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic [4:0] phyAddr,
   input wire logic [pedsc_pkg::NUM_COND-1:0] eventCond,
   input wire logic sleepRequest,
   output logic interruptOut,
   output logic deepSleep,
   output logic pllPowerDown,
   output logic fastRxPowerDown,
   output logic txDacPowerDown,
   output logic clockRecoveryPowerDown,
   output logic [5:0] fifoHalfBits
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic mdcMeta;
   logic mdcSync;
   logic mdcLast;
   logic mdioMeta;
   logic mdioSync;
   logic [4:0] phyMeta;
   logic [4:0] phySync;
   always_ff @(posedge clk) begin
      if (srst) begin
         mdcMeta <= 1'b0;
         mdcSync <= 1'b0;
         mdcLast <= 1'b0;
         mdioMeta <= 1'b1;
         mdioSync <= 1'b1;
         phyMeta <= 5'h00;
         phySync <= 5'h00;
      end else begin
         mdcMeta <= mdc;
         mdcSync <= mdcMeta;
         mdcLast <= mdcSync;
         mdioMeta <= mdioIn;
         mdioSync <= mdioMeta;
         phyMeta <= phyAddr;
         phySync <= phyMeta;
      end
   end
   wire logic mdcRise;
   assign mdcRise = mdcSync & ~mdcLast;
   // ----------------------------------------------------------------
   // frame state
   // ----------------------------------------------------------------
   pedsc_pkg::pedsc_frame_e frameState;
   pedsc_pkg::pedsc_frame_e next_frameState;
   logic [4:0] bitCnt;
   logic [4:0] next_bitCnt;
   logic [5:0] onesCnt;
   logic [5:0] next_onesCnt;
   logic [15:0] inShift;
   logic [15:0] outShift;
   logic [15:0] next_outShift;
   logic isRead;
   logic next_isRead;
   logic [4:0] regSel;
   logic [4:0] next_regSel;
   logic next_mdioOut;
   logic next_mdioOe;
   logic rdStrobe;
   logic wrStrobe;
   wire logic [15:0] shiftIn;
   wire logic addrHit;
   wire logic opRead;
   wire logic opWrite;
   wire logic [15:0] readData;
   assign shiftIn = {inShift[14:0], mdioSync};
   assign addrHit = shiftIn[9:5] == phySync;
   assign opRead = shiftIn[11:10] == pedsc_pkg::OP_READ;
   assign opWrite = shiftIn[11:10] == pedsc_pkg::OP_WRITE;
   always_comb begin
      next_frameState = frameState;
      next_bitCnt = bitCnt;
      next_onesCnt = onesCnt;
      next_outShift = outShift;
      next_isRead = isRead;
      next_regSel = regSel;
      next_mdioOut = mdioOut;
      next_mdioOe = mdioOe;
      rdStrobe = 1'b0;
      wrStrobe = 1'b0;
      if (mdcRise) begin
         next_bitCnt = 5'(bitCnt + 5'h01);
         case (frameState)
            pedsc_pkg::FR_PREAMBLE: begin
               next_bitCnt = 5'h00;
               if (mdioSync) begin
                  if (onesCnt != pedsc_pkg::PREAMBLE_LEN) begin
                     next_onesCnt = 6'(onesCnt + 6'h01);
                  end
               end else begin
                  next_onesCnt = 6'h00;
                  if (onesCnt == pedsc_pkg::PREAMBLE_LEN) begin
                     next_frameState = pedsc_pkg::FR_START;
                  end
               end
            end
            pedsc_pkg::FR_START: begin
               next_bitCnt = 5'h00;
               next_frameState = mdioSync ? pedsc_pkg::FR_OPCODE : pedsc_pkg::FR_PREAMBLE;
            end
            pedsc_pkg::FR_OPCODE: begin
               if (bitCnt == pedsc_pkg::OP_BITS - 5'h01) begin
                  next_bitCnt = 5'h00;
                  next_frameState = pedsc_pkg::FR_ADDR;
               end
            end
            pedsc_pkg::FR_ADDR: begin
               if (bitCnt == pedsc_pkg::ADDR_BITS - 5'h01) begin
                  next_bitCnt = 5'h00;
                  next_regSel = shiftIn[4:0];
                  next_isRead = opRead;
                  if (addrHit && (opRead || opWrite)) begin
                     next_frameState = pedsc_pkg::FR_TURN;
                     if (opRead) begin
                        rdStrobe = 1'b1;
                        next_outShift = readData;
                     end
                  end else begin
                     next_frameState = pedsc_pkg::FR_PREAMBLE;
                  end
               end
            end
            pedsc_pkg::FR_TURN: begin
               if (bitCnt == 5'h00) begin
                  if (isRead) begin
                     next_mdioOe = 1'b1;
                     next_mdioOut = 1'b0;
                  end
               end else begin
                  next_bitCnt = 5'h00;
                  if (isRead) begin
                     next_frameState = pedsc_pkg::FR_RDATA;
                     next_mdioOut = outShift[15];
                     next_outShift = {outShift[14:0], 1'b0};
                  end else begin
                     next_frameState = pedsc_pkg::FR_WDATA;
                  end
               end
            end
            pedsc_pkg::FR_RDATA: begin
               if (bitCnt == pedsc_pkg::DATA_BITS - 5'h01) begin
                  next_bitCnt = 5'h00;
                  next_mdioOe = 1'b0;
                  next_mdioOut = 1'b0;
                  next_frameState = pedsc_pkg::FR_PREAMBLE;
               end else begin
                  next_mdioOut = outShift[15];
                  next_outShift = {outShift[14:0], 1'b0};
               end
            end
            pedsc_pkg::FR_WDATA: begin
               if (bitCnt == pedsc_pkg::DATA_BITS - 5'h01) begin
                  next_bitCnt = 5'h00;
                  wrStrobe = 1'b1;
                  next_frameState = pedsc_pkg::FR_PREAMBLE;
               end
            end
            default: begin
               next_bitCnt = 5'h00;
               next_frameState = pedsc_pkg::FR_PREAMBLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         frameState <= pedsc_pkg::FR_PREAMBLE;
         bitCnt <= 5'h00;
         onesCnt <= 6'h00;
         inShift <= 16'h0000;
         outShift <= 16'h0000;
         isRead <= 1'b0;
         regSel <= 5'h00;
         mdioOut <= 1'b0;
         mdioOe <= 1'b0;
      end else begin
         frameState <= next_frameState;
         bitCnt <= next_bitCnt;
         onesCnt <= next_onesCnt;
         inShift <= mdcRise ? shiftIn : inShift;
         outShift <= next_outShift;
         isRead <= next_isRead;
         regSel <= next_regSel;
         mdioOut <= next_mdioOut;
         mdioOe <= next_mdioOe;
      end
   end
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] irqEnable;
   logic [3:0] fifoHalf;
   logic [2:0] fsReserved;
   logic sleepEnable;
   logic [3:0] blockSleepEn;
   wire logic [pedsc_pkg::NUM_FLAGS-1:0] flags;
   wire logic wrEnable;
   wire logic wrStatus;
   wire logic wrFifoSleep;
   assign wrEnable = wrStrobe & (regSel == pedsc_pkg::REG_IRQ_ENABLE);
   assign wrStatus = wrStrobe & (regSel == pedsc_pkg::REG_IRQ_STATUS);
   assign wrFifoSleep = wrStrobe & (regSel == pedsc_pkg::REG_FIFO_SLEEP);
   always_ff @(posedge clk) begin
      if (srst) begin
         irqEnable <= pedsc_pkg::EN_RESET;
         fifoHalf <= pedsc_pkg::FIFO_HALF_RESET;
         fsReserved <= 3'h0;
         sleepEnable <= 1'b0;
         blockSleepEn <= 4'h0;
      end else begin
         if (wrEnable) begin
            irqEnable <= shiftIn;
         end
         if (wrFifoSleep) begin
            fifoHalf <= shiftIn[pedsc_pkg::FS_FIFO_LSB +: 4];
            fsReserved <= shiftIn[pedsc_pkg::FS_RSVD_LSB +: 3];
            sleepEnable <= shiftIn[pedsc_pkg::FS_SLEEP_EN];
            blockSleepEn <= shiftIn[pedsc_pkg::FS_CLK_REC +: 4];
         end
      end
   end
   // read mux, upper status bits read zero
   wire logic [15:0] statusWord;
   wire logic [15:0] fifoSleepWord;
   assign statusWord = {{(16 - pedsc_pkg::NUM_FLAGS){1'b0}}, flags};
   assign fifoSleepWord = {fifoHalf, fsReserved, sleepEnable, blockSleepEn, 4'h0};
   assign readData = (shiftIn[4:0] == pedsc_pkg::REG_IRQ_ENABLE) ? irqEnable :
                     (shiftIn[4:0] == pedsc_pkg::REG_IRQ_STATUS) ? statusWord :
                     (shiftIn[4:0] == pedsc_pkg::REG_FIFO_SLEEP) ? fifoSleepWord : 16'h0000;
   // ----------------------------------------------------------------
   // deep sleep
   // ----------------------------------------------------------------
   pedsc_pkg::pedsc_sleep_e sleepState;
   pedsc_pkg::pedsc_sleep_e next_sleepState;
   logic enterPulse;
   logic wakePulse;
   logic [pedsc_pkg::NUM_COND-1:0] condLast;
   always_comb begin
      next_sleepState = sleepState;
      enterPulse = 1'b0;
      wakePulse = 1'b0;
      case (sleepState)
         pedsc_pkg::SL_AWAKE: begin
            if (sleepEnable && sleepRequest) begin
               next_sleepState = pedsc_pkg::SL_ASLEEP;
               enterPulse = 1'b1;
            end
         end
         pedsc_pkg::SL_ASLEEP: begin
            if (!sleepEnable || !sleepRequest) begin
               next_sleepState = pedsc_pkg::SL_AWAKE;
               wakePulse = 1'b1;
            end
         end
         default: begin
            next_sleepState = pedsc_pkg::SL_AWAKE;
         end
      endcase
   end
   wire logic asleepNext;
   assign asleepNext = next_sleepState == pedsc_pkg::SL_ASLEEP;
   always_ff @(posedge clk) begin
      if (srst) begin
         sleepState <= pedsc_pkg::SL_AWAKE;
         deepSleep <= 1'b0;
         pllPowerDown <= 1'b0;
         fastRxPowerDown <= 1'b0;
         txDacPowerDown <= 1'b0;
         clockRecoveryPowerDown <= 1'b0;
         condLast <= '0;
      end else begin
         sleepState <= next_sleepState;
         deepSleep <= asleepNext;
         pllPowerDown <= asleepNext & blockSleepEn[pedsc_pkg::FS_PLL - 4];
         fastRxPowerDown <= asleepNext & blockSleepEn[pedsc_pkg::FS_FAST_RX - 4];
         txDacPowerDown <= asleepNext & blockSleepEn[pedsc_pkg::FS_TX_DAC - 4];
         clockRecoveryPowerDown <= asleepNext & blockSleepEn[pedsc_pkg::FS_CLK_REC - 4];
         condLast <= eventCond;
      end
   end
   // ----------------------------------------------------------------
   // events and flags
   // ----------------------------------------------------------------
   wire logic isAsleep;
   wire logic [pedsc_pkg::NUM_FLAGS-1:0] eventPulse;
   wire logic [pedsc_pkg::NUM_FLAGS-1:0] eventLevel;
   wire logic readClear;
   wire logic [pedsc_pkg::NUM_FLAGS-1:0] writeClear;
   assign isAsleep = sleepState == pedsc_pkg::SL_ASLEEP;
   assign eventPulse = {wakePulse, enterPulse, eventCond & ~condLast};
   assign eventLevel = {~isAsleep, isAsleep, eventCond};
   assign readClear = rdStrobe & (shiftIn[4:0] == pedsc_pkg::REG_IRQ_STATUS) &
                      irqEnable[pedsc_pkg::EN_READ_CLEAR];
   assign writeClear = wrStatus ? shiftIn[pedsc_pkg::NUM_FLAGS-1:0] : '0;
   pedsc_event_flags u_flags (
      .clk(clk),
      .srst(srst),
      .eventPulse(eventPulse),
      .eventLevel(eventLevel),
      .readClear(readClear),
      .writeClear(writeClear),
      .autoClearEn(irqEnable[pedsc_pkg::EN_AUTO_CLEAR]),
      .resetupEn(irqEnable[pedsc_pkg::EN_RESETUP]),
      .flags(flags)
   );
   // ----------------------------------------------------------------
   // interrupt and fifo outputs
   // ----------------------------------------------------------------
   wire logic irqActive;
   assign irqActive = irqEnable[pedsc_pkg::EN_GLOBAL] &
                      (|(flags & irqEnable[pedsc_pkg::NUM_FLAGS-1:0]));
   always_ff @(posedge clk) begin
      if (srst) begin
         interruptOut <= 1'b1;
         fifoHalfBits <= 6'h00;
      end else begin
         interruptOut <= irqEnable[pedsc_pkg::EN_POLARITY] ? irqActive : ~irqActive;
         fifoHalfBits <= 6'(({2'h0, fifoHalf} + pedsc_pkg::FIFO_BIAS)
                            << pedsc_pkg::FIFO_SCALE_SHIFT);
      end
   end
endmodule // pedsc_top

// *** tb/pedsc_mgmt_host.sv ***
// station management controller model driving management frames
`timescale 1ns/1ps
module pedsc_mgmt_host (
   input wire logic clk,
   input wire logic mdioLine,
   input wire logic [4:0] phyAddr,
   output logic mdc,
   output logic hostOut,
   output logic hostOe
);
   initial begin
      mdc = 1'b0;
      hostOut = 1'b0;
      hostOe = 1'b0;
   end
   // ----------
   // one mdc period of 16 clk, line sampled late in the high phase
   // ----------
   task automatic mdc_bit(input logic b, input logic drive, output logic s);
      hostOut <= b;
      hostOe <= drive;
      mdc <= 1'b0;
      repeat (8) @(posedge clk);
      mdc <= 1'b1;
      repeat (8) @(posedge clk);
      s = mdioLine;
   endtask
   // ----------
   // whole frame, mdc parked low afterwards
   // ----------
   task automatic frame(input logic [1:0] op, input logic [4:0] regAddr,
      input logic [15:0] wdata, output logic [15:0] rdata);
      logic [45:0] head;
      logic [17:0] tail;
      logic s;
      head = {32'hffffffff, 2'h1, op, phyAddr, regAddr};
      tail = {2'h2, wdata};
      rdata = 16'h0000;
      for (int i = 45; i >= 0; i--) mdc_bit(head[i], 1'b1, s);
      if (op == pedsc_pkg::OP_WRITE) begin
         for (int i = 17; i >= 0; i--) mdc_bit(tail[i], 1'b1, s);
      end else begin
         // any register read: line released for the turnaround, then the data bits sampled
         mdc_bit(1'b1, 1'b0, s);
         for (int i = 0; i < 17; i++) begin
            mdc_bit(1'b1, 1'b0, s);
            if (i < 16) rdata = {rdata[14:0], s};
         end
      end
      mdc <= 1'b0;
      hostOe <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule // pedsc_mgmt_host

// *** tb/pedsc_properties.sv ***
// port assertions for the event interrupt and deep sleep control block
`timescale 1ns/1ps
module pedsc_properties (
   input wire logic clk,
   input wire logic srst,
   input wire logic mdc,
   input wire logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic [4:0] phyAddr,
   input wire logic [pedsc_pkg::NUM_COND-1:0] eventCond,
   input wire logic sleepRequest,
   input wire logic interruptOut,
   input wire logic deepSleep,
   input wire logic pllPowerDown,
   input wire logic fastRxPowerDown,
   input wire logic txDacPowerDown,
   input wire logic clockRecoveryPowerDown,
   input wire logic [5:0] fifoHalfBits
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ----------
   // cycles since any cause of an interrupt change
   // ----------
   logic [pedsc_pkg::NUM_COND-1:0] condQ;
   logic sleepQ;
   logic [3:0] quietCnt;
   always_ff @(posedge clk) begin
      condQ <= eventCond;
      sleepQ <= deepSleep;
      if (srst || mdc || eventCond != condQ || deepSleep != sleepQ) begin
         quietCnt <= 4'h0;
      end else if (quietCnt != 4'hf) begin
         quietCnt <= quietCnt + 4'h1;
      end
   end
   // ----------
   // assertions
   // ----------
   a_irq_quiet_stable: assert property (quietCnt > 4'h6 |-> $stable(interruptOut))
      else $error("interrupt output moved with no cause");
   a_reset_outputs: assert property ($fell(srst) |->
      interruptOut && !deepSleep && !mdioOe)
      else $error("outputs not idle after reset");
   a_fifo_after_rst: assert property ($fell(srst) |=> fifoHalfBits == 6'h0a)
      else $error("fifo half bits not default after reset");
   a_fifo_range: assert property (!$past(srst) |->
      !fifoHalfBits[0] && fifoHalfBits inside {[6'h06:6'h24]})
      else $error("fifo half bits out of range");
   a_sleep_needs_req: assert property ($rose(deepSleep) |-> $past(sleepRequest))
      else $error("deep sleep entered without request");
   a_sleep_exit: assert property (deepSleep && !sleepRequest |=> !deepSleep)
      else $error("deep sleep kept without request");
   a_pll_in_sleep: assert property (pllPowerDown |-> deepSleep)
      else $error("pll down outside deep sleep");
   a_rx_in_sleep: assert property ($rose(fastRxPowerDown) |-> deepSleep)
      else $error("receive block down outside deep sleep");
   a_dac_cdr_sleep: assert property (txDacPowerDown ||
      clockRecoveryPowerDown |-> deepSleep)
      else $error("dac or clock recovery down outside deep sleep");
   a_pd_release: assert property ($fell(deepSleep) |->
      !(pllPowerDown || fastRxPowerDown || txDacPowerDown || clockRecoveryPowerDown))
      else $error("power down kept after wake");
   c_sleep_entry: cover property ($rose(deepSleep));
   c_irq_active: cover property ($fell(interruptOut));
   c_read_answer: cover property ($fell(mdioOe));
endmodule // pedsc_properties

bind pedsc_top pedsc_properties u_props (.clk(clk), .srst(srst), .mdc(mdc), .mdioIn(mdioIn),
   .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(phyAddr), .eventCond(eventCond),
   .sleepRequest(sleepRequest), .interruptOut(interruptOut), .deepSleep(deepSleep),
   .pllPowerDown(pllPowerDown), .fastRxPowerDown(fastRxPowerDown),
   .txDacPowerDown(txDacPowerDown), .clockRecoveryPowerDown(clockRecoveryPowerDown),
   .fifoHalfBits(fifoHalfBits));

// *** tb/phy_event_irq_and_deep_sleep_ctl_test.sv ***
// self-checking bench for the event interrupt and deep sleep control block
`timescale 1ns/1ps
module phy_event_irq_and_deep_sleep_ctl_test;
   logic clk;
   logic srst;
   logic mdc;
   logic hostOut;
   logic hostOe;
   logic mdioOut;
   logic mdioOe;
   logic mdioLine;
   logic [pedsc_pkg::NUM_COND-1:0] eventCond;
   logic sleepRequest;
   logic interruptOut;
   logic deepSleep;
   logic pllPowerDown;
   logic fastRxPowerDown;
   logic txDacPowerDown;
   logic clockRecoveryPowerDown;
   logic [5:0] fifoHalfBits;
   logic [4:0] sleepOuts;
   int mismatches;
   int cmp_count;
   // shared line with pull-up
   assign mdioLine = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);
   assign sleepOuts = {deepSleep, pllPowerDown, fastRxPowerDown, txDacPowerDown,
      clockRecoveryPowerDown};
   pedsc_top DUT (.clk(clk), .srst(srst), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut),
      .mdioOe(mdioOe), .phyAddr(5'h05), .eventCond(eventCond), .sleepRequest(sleepRequest),
      .interruptOut(interruptOut), .deepSleep(deepSleep), .pllPowerDown(pllPowerDown),
      .fastRxPowerDown(fastRxPowerDown), .txDacPowerDown(txDacPowerDown),
      .clockRecoveryPowerDown(clockRecoveryPowerDown), .fifoHalfBits(fifoHalfBits));
   pedsc_mgmt_host host (.clk(clk), .mdioLine(mdioLine), .phyAddr(5'h05), .mdc(mdc),
      .hostOut(hostOut), .hostOe(hostOe));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ----------
   // checks and bus tasks
   // ----------
   task automatic check(input logic [15:0] got, input logic [15:0] expv, input string what);
      cmp_count++;
      if (got !== expv) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, expv);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] expv);
      logic [15:0] d;
      host.frame(pedsc_pkg::OP_READ, a, 16'h0000, d);
      check(d, expv, "register read");
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      logic [15:0] d;
      host.frame(pedsc_pkg::OP_WRITE, a, v, d);
   endtask
   task automatic pulse(input int i);
      eventCond[i] <= 1'b1;
      repeat (4) @(posedge clk);
      eventCond[i] <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   // ----------
   // main sequence
   // ----------
   initial begin
      logic [15:0] expv;
      srst = 1'b1;
      eventCond = 9'h000;
      sleepRequest = 1'b0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      check({10'h000, fifoHalfBits}, 16'h000a, "fifo bits");
      check({15'h0000, interruptOut}, 16'h0001, "irq idle");
      rd(pedsc_pkg::REG_IRQ_ENABLE, 16'h0000);
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0000);
      rd(pedsc_pkg::REG_FIFO_SLEEP, 16'h2000);
      rd(5'h1f, 16'h0000);
      wr(pedsc_pkg::REG_IRQ_ENABLE, 16'h80ff);
      rd(pedsc_pkg::REG_IRQ_ENABLE, 16'h80ff);
      for (int i = 0; i < 9; i++) begin
         expv = 16'h0001 << i;
         pulse(i);
         check({15'h0000, interruptOut}, {15'h0000, i == 8}, "irq level");
         rd(pedsc_pkg::REG_IRQ_STATUS, expv);
         wr(pedsc_pkg::REG_IRQ_STATUS, expv);
         rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0000);
         check({15'h0000, interruptOut}, 16'h0001, "irq cleared");
      end
      wr(pedsc_pkg::REG_IRQ_ENABLE, 16'ha080);
      pulse(7);
      check({15'h0000, interruptOut}, 16'h0001, "irq high polarity");
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0080);
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0080);
      wr(pedsc_pkg::REG_IRQ_ENABLE, 16'h4000);
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0080);
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0000);
      wr(pedsc_pkg::REG_IRQ_ENABLE, 16'h1000);
      eventCond[1] <= 1'b1;
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0002);
      eventCond[1] <= 1'b0;
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0000);
      wr(pedsc_pkg::REG_IRQ_ENABLE, 16'h0800);
      eventCond[2] <= 1'b1;
      wr(pedsc_pkg::REG_IRQ_STATUS, 16'h0004);
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0004);
      eventCond[2] <= 1'b0;
      wr(pedsc_pkg::REG_IRQ_STATUS, 16'h0004);
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0000);
      sleepRequest <= 1'b1;
      repeat (8) @(posedge clk);
      check({11'h000, sleepOuts}, 16'h0000, "sleep disabled");
      wr(pedsc_pkg::REG_FIFO_SLEEP, 16'h2150);
      check({11'h000, sleepOuts}, 16'h0015, "sleep outputs");
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0200);
      wr(pedsc_pkg::REG_FIFO_SLEEP, 16'h21a0);
      check({11'h000, sleepOuts}, 16'h001a, "sleep outputs");
      sleepRequest <= 1'b0;
      repeat (8) @(posedge clk);
      check({11'h000, sleepOuts}, 16'h0000, "awake outputs");
      rd(pedsc_pkg::REG_IRQ_STATUS, 16'h0600);
      wr(pedsc_pkg::REG_FIFO_SLEEP, 16'hf00f);
      rd(pedsc_pkg::REG_FIFO_SLEEP, 16'hf000);
      check({10'h000, fifoHalfBits}, 16'h0024, "fifo bits");
      wr(pedsc_pkg::REG_FIFO_SLEEP, 16'h0000);
      check({10'h000, fifoHalfBits}, 16'h0006, "fifo bits");
      give_verdict();
   end
endmodule // phy_event_irq_and_deep_sleep_ctl_test
